// *** design/sas_pkg.sv ***
// sas_pkg: shared constants and types of the SAR converter sequencer
package sas_pkg;

	// register word indexes; byte address is index times four
	localparam logic [9:0] CTL_IDX      = 10'h0F7;
	localparam logic [9:0] RESH_IDX     = 10'h0F8;
	localparam logic [9:0] RESL_IDX     = 10'h0F9;
	localparam logic [9:0] IRQ_STAT_IDX = 10'h0FA;
	localparam logic [9:0] IRQ_MASK_IDX = 10'h0FB;

	// converter_control field positions
	localparam int CHAN_MSB  = 7;
	localparam int CHAN_LSB  = 4;
	localparam int EOC_BIT   = 3;
	localparam int SPD_MSB   = 2;
	localparam int SPD_LSB   = 1;
	localparam int START_BIT = 0;

	// reset values
	localparam logic [3:0] CHAN_RST = 4'hF;
	localparam logic [1:0] SPD_RST  = 2'h0;

	localparam logic [3:0] CHAN_OFF   = 4'hF;
	localparam int         CHAN_COUNT = 13;
	localparam logic [11:0] SAR_HALF  = 12'h800;

	// conversion timing in conversion clocks
	localparam logic [2:0] SAMPLE_CLKS = 3'h5;
	localparam logic [4:0] BIT_CLKS    = 5'h0C;
	localparam logic [4:0] CONV_CLKS   = 5'h11;

	// oscillator periods per conversion clock, by speed code
	localparam logic [1:0] SPD_12   = 2'h1;
	localparam logic [4:0] DIV_SPD0 = 5'h10;
	localparam logic [4:0] DIV_SPD1 = 5'h0C;
	localparam logic [4:0] DIV_SPD2 = 5'h08;
	localparam logic [4:0] DIV_SPD3 = 5'h04;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONV   = 4'b0100,
		ST_DONE   = 4'b1000
	} sas_state_t;

endpackage

// *** design/sas_sar_reg.sv ***
// sas_sar_reg: successive approximation register, one bit per step
`timescale 1ns/10ps
`default_nettype none
module sas_sar_reg
	import sas_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        load,
	input  wire logic        step,
	input  wire logic        cmp,
	output var  logic [11:0] code,
	output var  logic        last
);
	logic [11:0] mask;

	// keep or drop the trial bit, then try the next lower one
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			code <= 12'h000;
			mask <= 12'h000;
		end else if (load) begin
			code <= SAR_HALF;
			mask <= SAR_HALF;
		end else if (step) begin
			code <= (cmp ? code : (code & ~mask)) | (mask >> 1);
			mask <= mask >> 1;
		end
	end

	assign last = mask[0];

	AST_SAR_DROP: assert property (@(posedge clk_sys) disable iff (srst)
		step && !cmp && !load |=> (code & $past(mask)) == 12'h000)
		else $error("rejected trial bit was kept");

endmodule
`default_nettype wire

// *** design/sas_sequencer.sv ***
// sas_sequencer: register file and sequencing of a 12-bit SAR converter
// What this block does
// - a 4-bit channel field routes at most one of thirteen inputs at a time
// - channel code all-ones shuts the converter down; otherwise it idles powered
// - setting control bit 0 while idle starts a conversion of the selected channel, unless that write's channel code is all-ones
// - approximation register loads half scale at start, then updates each step
// - five sampling clocks then twelve bit clocks, seventeen in total
// - at completion set end-of-conversion, store the result, go idle
// - upper 8 result bits in the high register, lower 4 in the low one
// - a new result overwrites the previous one
// - 2-bit speed field picks the conversion clock; code 01 is 12 periods
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer
	import sas_pkg::*;
#(
	parameter logic [4:0] DIV_S0 = DIV_SPD0,
	parameter logic [4:0] DIV_S1 = DIV_SPD1,
	parameter logic [4:0] DIV_S2 = DIV_SPD2,
	parameter logic [4:0] DIV_S3 = DIV_SPD3
) (
	input  wire logic        CLK_SYS,
	input  wire logic        SRST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [11:0] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output var  logic [31:0] WB_DAT_O,
	output var  logic        WB_ACK_O,
	output var  logic        IRQ,
	input  wire logic        CMP_IN,
	output var  logic [11:0] DAC_CODE,
	output var  logic        SH_SAMPLE,
	output var  logic [12:0] CH_SEL,
	output var  logic        ADC_PWR
);

	// register state
	logic [3:0]  chan;
	logic [1:0]  speed;
	logic        eoc;
	logic        start_pend;
	logic [11:0] result;
	logic        irq_stat;
	logic        irq_mask;

	// sequencing state
	sas_state_t  state;
	sas_state_t  next_state;
	logic [2:0]  samp_cnt;
	logic        tick;
	logic        div_clr;
	logic        sar_load;
	logic        sar_step;
	logic        sar_last;
	logic [11:0] sar_code;
	logic        powered;

	// bus decode
	logic        req;
	logic        wr;
	logic [9:0]  idx;
	logic        wr_ctl;
	logic        wr_stat;
	logic        wr_mask;
	logic        start_accept;
	logic [31:0] next_rdata;

	assign req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr      = req && WB_WE_I && WB_SEL_I[0];
	assign idx     = WB_ADR_I[11:2];
	assign wr_ctl  = wr && (idx == CTL_IDX);
	assign wr_stat = wr && (idx == IRQ_STAT_IDX);
	assign wr_mask = wr && (idx == IRQ_MASK_IDX);
	assign powered = (chan != CHAN_OFF);

	// start only from idle and only with a live channel in the same write
	assign start_accept = wr_ctl && WB_DAT_I[START_BIT] && (state == ST_IDLE)
		&& (WB_DAT_I[CHAN_MSB:CHAN_LSB] != CHAN_OFF);

	// channel and speed fields
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			chan  <= CHAN_RST;
			speed <= SPD_RST;
		end else if (wr_ctl) begin
			chan  <= WB_DAT_I[CHAN_MSB:CHAN_LSB];
			speed <= WB_DAT_I[SPD_MSB:SPD_LSB];
		end
	end

	// start bit: one pulse per accepted write
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			start_pend <= 1'b0;
		end else if (start_accept) begin
			start_pend <= 1'b1;
		end else if (state == ST_IDLE) begin
			start_pend <= 1'b0;
		end else begin
			start_pend <= 1'b0;
		end
	end

	// end-of-conversion flag, cleared by the start write itself
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			eoc <= 1'b0;
		end else if (state == ST_DONE) begin
			eoc <= 1'b1;
		end else if (start_accept) begin
			eoc <= 1'b0;
		end
	end

	// sequence state
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_pend && powered) begin
					next_state = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (!powered) begin
					next_state = ST_IDLE;
				end else if (tick && (samp_cnt == SAMPLE_CLKS - 3'h1)) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (!powered) begin
					next_state = ST_IDLE;
				end else if (tick && sar_last) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// sampling clocks counted in conversion ticks
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			samp_cnt <= 3'h0;
		end else if (state != ST_SAMPLE) begin
			samp_cnt <= 3'h0;
		end else if (tick) begin
			samp_cnt <= samp_cnt + 3'h1;
		end
	end

	assign div_clr  = (state == ST_IDLE);
	assign sar_load = (state == ST_IDLE) && (next_state == ST_SAMPLE);
	assign sar_step = (state == ST_CONV) && tick;

	sas_tick_div #(
		.DIV0 (DIV_S0),
		.DIV1 (DIV_S1),
		.DIV2 (DIV_S2),
		.DIV3 (DIV_S3)
	) u_div (
		.clk_sys (CLK_SYS),
		.srst    (SRST),
		.clr     (div_clr),
		.speed   (speed),
		.tick    (tick)
	);

	sas_sar_reg u_sar (
		.clk_sys (CLK_SYS),
		.srst    (SRST),
		.load    (sar_load),
		.step    (sar_step),
		.cmp     (CMP_IN),
		.code    (sar_code),
		.last    (sar_last)
	);

	// result store, always overwritten
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			result <= 12'h000;
		end else if (state == ST_DONE) begin
			result <= sar_code;
		end
	end

	// interrupt status: completion sets, write of one clears, set wins
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			irq_stat <= 1'b0;
		end else if (state == ST_DONE) begin
			irq_stat <= 1'b1;
		end else if (wr_stat && WB_DAT_I[0]) begin
			irq_stat <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			irq_mask <= 1'b0;
		end else if (wr_mask) begin
			irq_mask <= WB_DAT_I[0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= irq_stat && irq_mask;
		end
	end

	// analog side controls
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ADC_PWR   <= 1'b0;
			SH_SAMPLE <= 1'b0;
		end else begin
			ADC_PWR   <= powered;
			SH_SAMPLE <= (next_state == ST_SAMPLE);
		end
	end

	// one-hot input routing; codes 13 and 14 route nothing
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			CH_SEL <= 13'h0000;
		end else begin
			for (int i = 0; i < CHAN_COUNT; i++) begin
				CH_SEL[i] <= powered && (chan == 4'(i));
			end
		end
	end

	assign DAC_CODE = sar_code;

	// register read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (req && !WB_WE_I) begin
			case (idx)
				CTL_IDX:      next_rdata[7:0] = {chan, eoc, speed, start_pend};
				RESH_IDX:     next_rdata[7:0] = result[11:4];
				RESL_IDX:     next_rdata[3:0] = result[3:0];
				IRQ_STAT_IDX: next_rdata[0]   = irq_stat;
				IRQ_MASK_IDX: next_rdata[0]   = irq_mask;
				default:      next_rdata      = 32'h0000_0000;
			endcase
		end
	end

	// single-wait acknowledge, also for unmapped addresses
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req;
			WB_DAT_O <= next_rdata;
		end
	end

	// checking helpers
	logic       st_samp;
	logic       st_done;
	logic       rd_hi;
	logic       rd_lo;
	logic [4:0] tick_cnt;

	assign st_samp = (state == ST_SAMPLE);
	assign st_done = (state == ST_DONE);
	assign rd_hi   = req && !WB_WE_I && (idx == RESH_IDX);
	assign rd_lo   = req && !WB_WE_I && (idx == RESL_IDX);

	always_ff @(posedge CLK_SYS) begin
		if (SRST || (state == ST_IDLE)) begin
			tick_cnt <= 5'h00;
		end else if (tick) begin
			tick_cnt <= tick_cnt + 5'h01;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	AST_ONE_CHANNEL: assert property ($countones(CH_SEL) <= 1)
		else $error("more than one input routed");

	AST_CH_MATCH: assert property (powered && chan < 4'hD |=> CH_SEL[$past(chan)])
		else $error("selected input not routed");

	AST_OFF_NO_POWER: assert property (!powered |=> !ADC_PWR && CH_SEL == 13'h0000)
		else $error("converter powered while shut down");

	AST_START_RUNS: assert property (start_accept |=> start_pend ##1 st_samp)
		else $error("start did not begin a conversion");

	AST_HALF_SCALE: assert property ($rose(st_samp) |-> DAC_CODE == SAR_HALF)
		else $error("trial code not at half scale at start");

	AST_SEVENTEEN: assert property (st_done |-> tick_cnt == CONV_CLKS)
		else $error("conversion length is not 17 clocks");

	AST_EOC_SET: assert property (st_done |=> eoc && state == ST_IDLE)
		else $error("completion not flagged");

	AST_SPLIT: assert property (WB_ACK_O && $past(rd_hi) && !$past(st_done)
		|-> WB_DAT_O == {24'h000000, result[11:4]})
		else $error("high result read wrong");

	AST_SPLIT_LO: assert property (WB_ACK_O && $past(rd_lo) && !$past(st_done)
		|-> WB_DAT_O == {28'h0000000, result[3:0]})
		else $error("low result read wrong");

	AST_OVERWRITE: assert property (st_done |=> result == $past(sar_code))
		else $error("result not replaced");

	AST_EOC_LOW: assert property (start_accept |=> !eoc until_with st_done)
		else $error("end flag set during conversion");

	AST_EOC_BOUND: assert property (start_accept && WB_DAT_I[SPD_MSB:SPD_LSB] == SPD_12
		|-> ##[200:230] eoc)
		else $error("conversion did not finish in time");

	AST_START_CLR: assert property (st_samp |-> !start_pend)
		else $error("start bit not cleared");

	CVR_DONE: cover property (st_done);
	CVR_ABORT: cover property (state == ST_CONV && !powered);
	CVR_IRQ: cover property (IRQ);
	CVR_SLOW: cover property (st_done && speed == 2'h0);

endmodule
`default_nettype wire

// *** design/sas_tick_div.sv ***
// sas_tick_div: conversion clock tick from the oscillator clock
`timescale 1ns/10ps
`default_nettype none
module sas_tick_div
	import sas_pkg::*;
#(
	parameter logic [4:0] DIV0 = DIV_SPD0,
	parameter logic [4:0] DIV1 = DIV_SPD1,
	parameter logic [4:0] DIV2 = DIV_SPD2,
	parameter logic [4:0] DIV3 = DIV_SPD3
) (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       clr,
	input  wire logic [1:0] speed,
	output var  logic       tick
);
	logic [4:0] cnt;
	logic [4:0] lim;

	always_comb begin
		case (speed)
			2'h0: lim = DIV0;
			2'h1: lim = DIV1;
			2'h2: lim = DIV2;
			default: lim = DIV3;
		endcase
	end

	// one tick every lim cycles; clr restarts the period
	always_ff @(posedge clk_sys) begin
		if (srst || clr) begin
			cnt  <= 5'h00;
			tick <= 1'b0;
		end else if (cnt == lim - 5'h01) begin
			cnt  <= 5'h00;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 5'h01;
			tick <= 1'b0;
		end
	end

	AST_DIV_12: assert property (@(posedge clk_sys) disable iff (srst || clr || speed != SPD_12)
		tick |=> (!tick)[*8] ##1 (!tick)[*3] ##1 tick)
		else $error("speed 01 tick spacing is not 12 cycles");

endmodule
`default_nettype wire

// *** tb/sas_testbench.sv ***
// sas_testbench: self-checking bench for the SAR converter sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench
	import sas_pkg::*;
;
	logic        clk_sys, srst, cyc, stb, we, cmp_in;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack, irq, sh_sample, adc_pwr, sh_q, irq_q;
	logic [11:0] dac_code, vin;
	logic [12:0] ch_sel;
	int          miscompares, checks_done;
	int          cnt = 0, t_sh = 0, t_irq = 0;
	localparam int DV[4] = '{8, 12, 6, 4};

	sas_sequencer #(
		.DIV_S0 (5'h08),
		.DIV_S1 (5'h0C),
		.DIV_S2 (5'h06),
		.DIV_S3 (5'h04)
	) i_dut (
		.CLK_SYS   (clk_sys),
		.SRST      (srst),
		.WB_CYC_I  (cyc),
		.WB_STB_I  (stb),
		.WB_WE_I   (we),
		.WB_ADR_I  (adr),
		.WB_SEL_I  (sel),
		.WB_DAT_I  (wdat),
		.WB_DAT_O  (rdat),
		.WB_ACK_O  (ack),
		.IRQ       (irq),
		.CMP_IN    (cmp_in),
		.DAC_CODE  (dac_code),
		.SH_SAMPLE (sh_sample),
		.CH_SEL    (ch_sel),
		.ADC_PWR   (adc_pwr)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic results();
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// comparator model: keeps the trial bit while the input is at or above it
	always @(posedge clk_sys) begin
		cmp_in <= (vin >= dac_code);
		cnt    <= cnt + 1;
		sh_q   <= sh_sample;
		irq_q  <= irq;
		if (sh_sample === 1'b1 && sh_q === 1'b0)
			t_sh <= cnt;
		if (irq === 1'b1 && irq_q === 1'b0)
			t_irq <= cnt;
		if (sh_sample === 1'b1)
			chk(dac_code, 12'h800);
	end

	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		wdat <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 100);
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 100)
			miscompares++;
	endtask

	task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
		logic [7:0] r;
		bus(1'b0, idx, 8'h00, r);
		chk(r, exp);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, idx, d, r);
	endtask

	// register reset values and an unmapped word
	task automatic t_reset();
		rd_chk(CTL_IDX, 8'hF0);
		rd_chk(RESH_IDX, 8'h00);
		rd_chk(RESL_IDX, 8'h00);
		rd_chk(IRQ_STAT_IDX, 8'h00);
		rd_chk(10'h020, 8'h00);
		chk(adc_pwr, 1'b0);
		chk(ch_sel, 13'h0000);
	endtask

	// one full conversion, checked for routing, timing, flags and result
	task automatic t_conv(input logic [3:0] ch, input logic [1:0] sp, input logic [11:0] v, input logic m);
		logic [7:0] r;
		int n, d;
		vin = v;
		wr(IRQ_MASK_IDX, {7'h0, m});
		wr(CTL_IDX, {ch, 1'b0, sp, 1'b1});
		if (sp == 2'h0)
			repeat (3) @(posedge clk_sys);
		bus(1'b0, CTL_IDX, 8'h00, r);
		chk(r & 8'hFE, {ch, 1'b0, sp, 1'b0});
		chk(ch_sel, (ch < 4'hD) ? (13'h0001 << ch) : 13'h0000);
		chk(adc_pwr, 1'b1);
		n = 0;
		do begin
			bus(1'b0, CTL_IDX, 8'h00, r);
			n++;
		end while (r[3] !== 1'b1 && n < 200);
		chk(r & 8'hFF, {ch, 1'b1, sp, 1'b0});
		repeat (2) @(posedge clk_sys);
		chk(irq, m);
		if (m) begin
			d = t_irq - t_sh;
			chk((d >= 17 * DV[sp] + 2 && d <= 17 * DV[sp] + 4), 1'b1);
		end
		rd_chk(RESH_IDX, v[11:4]);
		rd_chk(RESL_IDX, {4'h0, v[3:0]});
		rd_chk(IRQ_STAT_IDX, 8'h01);
		wr(IRQ_STAT_IDX, 8'h01);
		rd_chk(IRQ_STAT_IDX, 8'h00);
		chk(irq, 1'b0);
		chk(adc_pwr, 1'b1);
	endtask

	// shutdown in mid-conversion, then a start with the off code
	task automatic t_abort();
		vin = 12'h123;
		wr(CTL_IDX, 8'h37);
		repeat (30) @(posedge clk_sys);
		wr(CTL_IDX, 8'hF0);
		repeat (2) @(posedge clk_sys);
		chk(adc_pwr, 1'b0);
		chk(ch_sel, 13'h0000);
		wr(CTL_IDX, 8'hF1);
		repeat (100) @(posedge clk_sys);
		chk(sh_sample, 1'b0);
		rd_chk(CTL_IDX, 8'hF0);
		rd_chk(RESH_IDX, 8'hC9);
		rd_chk(IRQ_STAT_IDX, 8'h00);
	endtask

	initial begin
		srst = 1'b1;
		cyc  = 1'b0;
		stb  = 1'b0;
		we   = 1'b0;
		adr  = 12'h000;
		sel  = 4'hF;
		wdat = 32'h0;
		vin  = 12'h000;
		miscompares = 0;
		checks_done = 0;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset();
		t_conv(4'h0, 2'h1, 12'hA5C, 1'b1);
		t_conv(4'hC, 2'h0, 12'h3F1, 1'b1);
		t_conv(4'h5, 2'h2, 12'hFFF, 1'b0);
		t_conv(4'hD, 2'h3, 12'hC9E, 1'b1);
		t_abort();
		results();
	end

	initial begin
		#40000;
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
